// ---- lvds_pixel_serializer_cfg.svh ----
`ifndef LVDS_PIXEL_SERIALIZER_CFG_SVH
`define LVDS_PIXEL_SERIALIZER_CFG_SVH

// Word and lane geometry
`define WORD_BITS 28
`define COLOUR_BITS 24
`define LANE_COUNT 4
`define SLOTS_PER_LANE 7
`define SLOT_W 3
`define LAST_SLOT 3'h6

// Field positions inside the parallel word
`define LINE_SYNC_BIT 24
`define FRAME_SYNC_BIT 25
`define DATA_VALID_BIT 26
`define SPARE_BIT 27

// Forwarded clock shape over the seven slots, slot 0 first
`define FWD_CLK_PATTERN 7'h63

// Timing: system clock and pixel clock range
`define SYS_CLK_PERIOD_PS 8000
`define PIX_CLK_MAX_MHZ 85
`define PIX_CLK_MIN_MHZ 20
`define PIX_MIN_PERIOD_PS (1000000 / `PIX_CLK_MAX_MHZ)
`define PIX_MAX_PERIOD_PS (1000000 / `PIX_CLK_MIN_MHZ)
`define PIX_MIN_PERIOD_CYC \
  ((`PIX_MIN_PERIOD_PS + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS)
`define PIX_MAX_PERIOD_CYC (`PIX_MAX_PERIOD_PS / `SYS_CLK_PERIOD_PS)

// Period measurement width
`define PERIOD_W 8
`define PERIOD_SAT 8'hff

`endif

// ---- lvds_pixel_serializer_pkg.sv ----
`default_nettype none

package lvds_pixel_serializer_pkg;

  // Parallel word as the controller presents it
  typedef struct packed {
    logic spare;
    logic pixelDataValid;
    logic frameSync;
    logic lineSync;
    logic [23:0] colour;
  } pixel_word_t;

  // Everything that arrives from outside the system clock domain
  typedef struct packed {
    pixel_word_t word;
    logic pixelClock;
    logic strobeEdgeSelect;
    logic powerDownN;
  } pin_sample_t;

endpackage

`default_nettype wire

// ---- lvds_pixel_serializer.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lvds_pixel_serializer_cfg.svh"

module lvds_pixel_serializer
  import lvds_pixel_serializer_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller side pins
  input wire logic pixelClockIn,
  input wire pixel_word_t parallelPixelIn,
  input wire logic strobeEdgeSelect,
  input wire logic powerDownN,
  // Serial data lanes, true and complement with enable
  output logic [`LANE_COUNT-1:0] serialLaneOutP,
  output logic [`LANE_COUNT-1:0] serialLaneOutN,
  output logic [`LANE_COUNT-1:0] serialLaneOutEn,
  // Forwarded clock lane
  output logic forwardedClockOutP,
  output logic forwardedClockOutN,
  output logic forwardedClockOutEn,
  // Status
  output logic pixelClockInRange
);

  localparam int SLOTS = `SLOTS_PER_LANE;

  // Reset release through two flops
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Three-stage pin synchroniser; stage one feeds only stage two
  pin_sample_t pinNow;
  pin_sample_t s1;
  pin_sample_t s2;
  pin_sample_t s3;
  assign pinNow = '{word: parallelPixelIn, pixelClock: pixelClockIn,
                    strobeEdgeSelect: strobeEdgeSelect,
                    powerDownN: powerDownN};
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end
    else
    begin
      s1 <= pinNow;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered levels and serializer state
  logic clkLevel, next_clkLevel;
  logic selLevel, next_selLevel;
  logic pdnLevel, next_pdnLevel;
  logic strobe;
  logic [`WORD_BITS-1:0] shiftWord, next_shiftWord;
  logic [`SLOT_W-1:0] slot, next_slot;
  logic [`PERIOD_W-1:0] acc, next_acc;
  logic [`PERIOD_W-1:0] period, next_period;
  logic [`PERIOD_W-1:0] count, next_count;
  logic [`LANE_COUNT-1:0] laneBits, next_laneBits;
  logic fwdBit, next_fwdBit;
  logic outEn, next_outEn;
  logic [`PERIOD_W-1:0] accStep;
  logic [6:0] fwdPattern;

  assign fwdPattern = `FWD_CLK_PATTERN;
  assign accStep = acc + `PERIOD_W'(SLOTS);

  // A pin level counts only once stages two and three agree
  always_comb
  begin
    next_clkLevel = (s2.pixelClock == s3.pixelClock) ? s3.pixelClock
                                                     : clkLevel;
    next_selLevel = (s2.strobeEdgeSelect == s3.strobeEdgeSelect)
                    ? s3.strobeEdgeSelect : selLevel;
    next_pdnLevel = (s2.powerDownN == s3.powerDownN) ? s3.powerDownN
                                                     : pdnLevel;
    // New clock level equal to select picks rising or falling edge
    strobe = (s2.pixelClock == s3.pixelClock) &&
             (s3.pixelClock != clkLevel) &&
             (s3.pixelClock == selLevel);
  end

  // Word capture, period measure and slot pacing
  always_comb
  begin
    next_shiftWord = shiftWord;
    next_slot = slot;
    next_acc = acc;
    next_period = period;
    next_count = (count == `PERIOD_SAT) ? count : count + `PERIOD_W'(1);
    if (strobe)
    begin
      next_shiftWord = s3.word;
      next_slot = '0;
      next_acc = '0;
      // Saturate so a long idle pixel clock never reads as a short period
      next_period = (count == `PERIOD_SAT) ? count : count + `PERIOD_W'(1);
      next_count = '0;
    end
    // Seven slots spread over the last measured period
    else if (slot != `LAST_SLOT)
    begin
      if (accStep >= period)
      begin
        next_acc = accStep - period;
        next_slot = slot + `SLOT_W'(1);
      end
      else
      begin
        next_acc = accStep;
      end
    end
  end

  // Lane bit selection from the current slot
  always_comb
  begin
    for (int l = 0; l < `LANE_COUNT; l++)
    begin
      next_laneBits[l] = shiftWord[l * SLOTS + int'(slot)];
    end
    next_fwdBit = fwdPattern[6 - int'(slot)];
    next_outEn = pdnLevel;
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      clkLevel <= 1'b0;
      selLevel <= 1'b0;
      pdnLevel <= 1'b0;
      shiftWord <= '0;
      slot <= '0;
      acc <= '0;
      period <= '0;
      count <= '0;
      laneBits <= '0;
      fwdBit <= 1'b0;
      outEn <= 1'b0;
    end
    else
    begin
      clkLevel <= next_clkLevel;
      selLevel <= next_selLevel;
      pdnLevel <= next_pdnLevel;
      shiftWord <= next_shiftWord;
      slot <= next_slot;
      acc <= next_acc;
      period <= next_period;
      count <= next_count;
      laneBits <= next_laneBits;
      fwdBit <= next_fwdBit;
      outEn <= next_outEn;
    end
  end

  // Pad drive; complement forms the differential pair
  assign serialLaneOutP = laneBits;
  assign serialLaneOutN = ~laneBits;
  assign serialLaneOutEn = {`LANE_COUNT{outEn}};
  assign forwardedClockOutP = fwdBit;
  assign forwardedClockOutN = ~fwdBit;
  assign forwardedClockOutEn = outEn;
  // Informative only: the pads are not gated on it
  assign pixelClockInRange =
    (period >= `PERIOD_W'(`PIX_MIN_PERIOD_CYC)) &&
    (period <= `PERIOD_W'(`PIX_MAX_PERIOD_CYC));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync);

  pd_tristate_a: assert property (!pdnLevel |=>
    serialLaneOutEn == '0 && !forwardedClockOutEn)
    else $error("lanes driven during power-down");
  pd_release_a: assert property (pdnLevel ##1 pdnLevel |->
    serialLaneOutEn == '1 && forwardedClockOutEn)
    else $error("lanes not driven after power-up");
  // Every filtered clock edge strobes exactly when it matches the select
  rise_strobe_a: assert property ($rose(clkLevel) |->
    $past(strobe) == $past(selLevel))
    else $error("rising pixel clock edge strobe mismatch");
  fall_strobe_a: assert property ($fell(clkLevel) |->
    $past(strobe) != $past(selLevel))
    else $error("falling pixel clock edge strobe mismatch");
  word_capture_a: assert property (strobe |=>
    shiftWord == $past(s3.word) && slot == '0)
    else $error("pixel word not captured at strobe");
  lane_map_a: assert property (##1
    serialLaneOutP[3] == $past(shiftWord[21 + int'(slot)]) &&
    serialLaneOutP[0] == $past(shiftWord[int'(slot)]))
    else $error("lane bit mapping wrong");
  fwd_shape_a: assert property (slot == '0 ##1 slot == '0 |->
    forwardedClockOutP)
    else $error("forwarded clock low in first slot");
  slot_step_a: assert property (!strobe && slot != `LAST_SLOT |=>
    slot == $past(slot) || slot == $past(slot) + `SLOT_W'(1))
    else $error("slot skipped");
  period_meas_a: assert property (strobe && count != `PERIOD_SAT |=>
    period == $past(count) + `PERIOD_W'(1))
    else $error("pixel period mismeasured");

endmodule

`default_nettype wire

// ---- lvds_pixel_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module lvds_pixel_rx_model
(
  // Sampling clock
  input wire logic clk,
  // Lane wires, z while released
  input wire logic [3:0] lane,
  input wire logic fwd,
  // Rebuilt word and slots seen per word
  output logic [27:0] rxWord,
  output logic rxValid,
  output logic [3:0] rxRuns
);
  logic [4:0] last = 5'h00;
  logic [27:0] hist;
  logic [3:0] runs = 4'h0;

  // Every change on the wires starts a slot, so test words must keep
  // neighbouring slots distinct; the clock lane falling marks slot 2
  always @(posedge clk)
  begin
    rxValid <= 1'b0;
    if ({fwd, lane} !== last)
    begin
      last <= {fwd, lane};
      hist <= {hist[23:0], lane};
      runs <= (runs == 4'hf) ? runs : runs + 4'h1;
      if (last[4] === 1'b1 && fwd === 1'b0)
      begin
        runs <= 4'h1;
        rxRuns <= runs;
      end
      if (runs == 4'h5)
      begin
        for (int b = 0; b < 28; b++)
          rxWord[b] <= hist[4 * (6 - b % 7) + b / 7];
        rxValid <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- lvds_pixel_serializer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHECK(what, exp, seen) \
  begin checks++; if ((seen) !== (exp)) begin errors++; \
  $display("BAD %s exp %h got %h", what, exp, seen); end end

module lvds_pixel_serializer_tb import lvds_pixel_serializer_pkg::*;;
  int errors = 0;
  int checks = 0;
  int idx;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pixelClockIn = 1'b0;
  logic strobeEdgeSelect = 1'b1;
  logic powerDownN = 1'b1;
  pixel_word_t parallelPixelIn = '0;
  logic [3:0] laneP, laneN, laneEn, rxRuns;
  logic fwdP, fwdN, fwdEn, inRange, rxValid;
  logic [27:0] rxWord;
  logic [27:0] got[$];
  wire logic [3:0] laneWire;
  wire logic fwdWire = fwdEn ? fwdP : 1'bz;

  // Released lanes float
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    assign laneWire[l] = laneEn[l] ? laneP[l] : 1'bz;
  end

  lvds_pixel_serializer lvds_pixel_serializer_i (.clk(clk), .rst_n(rst_n),
    .pixelClockIn(pixelClockIn), .parallelPixelIn(parallelPixelIn),
    .strobeEdgeSelect(strobeEdgeSelect), .powerDownN(powerDownN),
    .serialLaneOutP(laneP), .serialLaneOutN(laneN),
    .serialLaneOutEn(laneEn), .forwardedClockOutP(fwdP),
    .forwardedClockOutN(fwdN), .forwardedClockOutEn(fwdEn),
    .pixelClockInRange(inRange));

  lvds_pixel_rx_model lvds_pixel_rx_model_i (.clk(clk), .lane(laneWire),
    .fwd(fwdWire), .rxWord(rxWord), .rxValid(rxValid), .rxRuns(rxRuns));

  // Clock and received word log
  initial
    forever #4 clk = ~clk;
  always @(posedge clk)
    if (rxValid === 1'b1)
      got.push_back(rxWord);

  // Lane 0 alternates within a word and lane 1 goes from low in slot 6 to high in slot 0 between words, so each slot shows as a change on the wires
  function automatic pixel_word_t mk(input logic [13:0] k);
    return {k * 14'h0b3d, 14'h1ad5};
  endfunction

  // One 80 ns pixel period; the word stands only around the strobe edge
  // and its inverse elsewhere, so a wrong sampling edge shows
  task automatic pixel(input pixel_word_t w);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      pixelClockIn <= strobeEdgeSelect ^ (i < 2 || i >= 7);
      parallelPixelIn <= (i < 5) ? w : ~w;
    end
  endtask

  // Eight words back to back; the middle ones must arrive whole, in order
  task automatic stream(input string name, input logic sel,
    input logic [13:0] b);
    @(posedge clk);
    strobeEdgeSelect <= sel;
    got.delete();
    for (int k = 0; k < 8; k++)
      pixel(mk(b + 14'(k)));
    idx = -1;
    foreach (got[j])
      if (got[j] === mk(b + 14'h3) && j + 2 < got.size())
        idx = j;
    `CHECK("word a", mk(b + 14'h3), idx < 0 ? 28'hx : got[idx])
    `CHECK("word b", mk(b + 14'h4), idx < 0 ? 28'hx : got[idx + 1])
    `CHECK("word c", mk(b + 14'h5), idx < 0 ? 28'hx : got[idx + 2])
    `CHECK("slots", 4'h7, rxRuns)
    `CHECK("lane n", ~laneP, laneN)
    `CHECK("fwd n", ~fwdP, fwdN)
    `CHECK("range", 1'b0, inRange)
    $display("%s done", name);
  endtask

  // Power-down floats every lane; release drives them again
  task automatic power_test;
    @(posedge clk);
    powerDownN <= 1'b0;
    pixel(mk(14'h0));
    `CHECK("enables off", 5'h00, {fwdEn, laneEn})
    powerDownN <= 1'b1;
    pixel(mk(14'h1));
    `CHECK("enables on", 5'h1f, {fwdEn, laneEn})
    $display("power done");
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence; the 80 ns pixel clock is slower than the range allows
  initial
  begin
    repeat (4) @(posedge clk);
    `CHECK("reset off", 5'h00, {fwdEn, laneEn})
    rst_n <= 1'b1;
    stream("rising", 1'b1, 14'h0010);
    stream("falling", 1'b0, 14'h0020);
    power_test();
    stream("resume", 1'b1, 14'h0030);
    end_of_test();
  end

  // Watchdog, about ten times the expected run
  initial
  begin
    #24000;
    errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
